// ### asd_decoder.sv
// Register file, program memory and data memory decoder for the core
//
// Summary of operation
// - Register file space is 4096 bytes: control and general-purpose parts.
// - Control registers occupy F00H through FFFH, the top 256 bytes.
// - Reserved control addresses read undefined; software should not write.
// - On-chip RAM starts at 000H, sized 256 bytes to 1KB.
// - Addresses between RAM and control read undefined, writes ignored.
// - Program space is 64KB, flash of 1KB to 4KB backs it.
// - Program reads past flash return FFH; writes there do nothing.
// - Low program layout: options, vectors, reserved 0038, oscillator traps.
// - General program memory runs from 003E to the flash end.
// - Data memory space decodes nothing.
// - Page select bit 7 enables the 128-byte information area.
// - When enabled, reads FE00H-FF7FH return information area bytes.
// - Information area is read-only; no write path exists.
// - Information area holds part number, options, calibration, reserved.
// - Instruction sources are read, destinations written in register file.
`timescale 1ns/1ps
`default_nettype none
module asd_decoder
    import asd_pkg::*;
#(
    parameter int RAM_BYTES   = RF_RAM_DEF_BYTES,
    parameter int FLASH_BYTES = PM_FLASH_DEF_BYTES,
    parameter logic [8*INFO_BYTES-1:0] INFO_IMAGE = {INFO_BYTES{BYTE_BLANK}}
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          clk_en,
    input  wire asd_rf_req_s   rfReq,
    output logic      [7:0]    rfRdata,
    output logic               ctrlSel,
    output logic      [7:0]    ctrlIndex,
    input  wire logic [7:0]    ctrlRdata,
    input  wire asd_pm_req_s   pmReq,
    output logic      [7:0]    pmRdata,
    output logic               flashWe,
    output logic      [15:0]   flashAddr,
    output logic      [7:0]    flashWdata,
    input  wire logic [7:0]    flashRdata,
    output logic      [2:0]    pmRegion,
    input  wire logic          dmRd,
    input  wire logic          dmWr,
    input  wire logic [15:0]   dmAddr,
    output logic      [7:0]    dmRdata,
    input  wire logic [7:0]    pageSelect
);
    localparam int RAM_AW = $clog2(RAM_BYTES);

    logic rstPipe;
    logic rstSync;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstPipe <= 1'b1;
            rstSync <= rstPipe;
        end
    end

    wire [RF_AW-1:0] rfAddr  = rfReq.addr;
    wire             rfCtrl  = rfAddr >= RF_CTRL_BASE;
    wire             rfRam   = (rfAddr - RF_RAM_BASE) < RF_AW'(RAM_BYTES);
    wire             rfGap   = !rfCtrl && !rfRam;
    wire             ramWe   = rfReq.wr && rfRam;
    wire             rfRamRd = rfReq.rd && rfRam;

    logic [7:0] ramRdata;
    asd_ram #(.DEPTH(RAM_BYTES), .AW(RAM_AW)) ramInst (
        .core_clk (core_clk),
        .ce       (clk_en),
        .we       (ramWe),
        .addr     (rfAddr[RAM_AW-1:0]),
        .wdata    (rfReq.wdata),
        .rdata    (ramRdata)
    );

    // reserved control reads come from the peripheral side as is
    // Frozen core must not strobe the peripherals
    assign ctrlSel   = rfCtrl && (rfReq.rd || rfReq.wr) && clk_en;
    assign ctrlIndex = rfAddr[7:0];

    asd_rf_region_e rfSelQ;
    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            rfSelQ <= ASD_RF_GAP;
        end else if (clk_en) begin
            rfSelQ <= rfCtrl ? ASD_RF_CTRL :
                      (rfRam ? ASD_RF_RAM : ASD_RF_GAP);
        end
    end

    logic [7:0] ctrlQ;
    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            ctrlQ <= BYTE_UNDEF;
        end else if (clk_en && ctrlSel) begin
            ctrlQ <= ctrlRdata;
        end
    end

    // gap reads give the undefined filler
    always_comb begin
        unique case (rfSelQ)
            ASD_RF_RAM:  rfRdata = ramRdata;
            ASD_RF_CTRL: rfRdata = ctrlQ;
            default:     rfRdata = BYTE_UNDEF;
        endcase
    end

    wire infoEn = pageSelect[PAGE_INFO_BIT];
    wire [15:0] pa = pmReq.addr;
    wire inOverlay = pa >= PM_INFO_BASE && pa <= PM_INFO_LAST;
    wire inFlash   = pa < 16'(FLASH_BYTES);
    wire isOpt  = pa < PM_RST_VEC;
    wire isVec  = (pa >= PM_RST_VEC && pa <= PM_IRQ_LAST) ||
                  (pa >= PM_OSC_BASE && pa <= PM_OSC_LAST);
    wire isRsv  = pa >= PM_RSV_BASE && pa < PM_OSC_BASE;
    wire isGen  = pa >= PM_GEN_BASE && inFlash;
    wire useInfo = infoEn && inOverlay;

    asd_pm_region_e nextRegion;
    assign nextRegion = useInfo ? ASD_PM_INFO :
                        !inFlash ? ASD_PM_NONE :
                        isOpt ? ASD_PM_OPT :
                        isVec ? ASD_PM_VEC :
                        isRsv ? ASD_PM_RSV : ASD_PM_GEN;

    // writes reach flash only inside it, never the info area
    assign flashWe    = pmReq.wr && inFlash && clk_en;
    assign flashAddr  = pa;
    assign flashWdata = pmReq.wdata;

    // info image: part number and other regions
    wire [6:0] infoIdx = pa[6:0];
    wire [7:0] infoByte = INFO_IMAGE[8*infoIdx +: 8];

    asd_pm_region_e pmSelQ;
    logic [7:0]     infoQ;
    always_ff @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            pmSelQ <= ASD_PM_NONE;
            infoQ  <= BYTE_BLANK;
        end else if (clk_en && pmReq.rd) begin
            pmSelQ <= nextRegion;
            infoQ  <= infoByte;
        end
    end
    assign pmRegion = pmSelQ;

    always_comb begin
        unique case (pmSelQ)
            ASD_PM_INFO: pmRdata = infoQ;
            ASD_PM_NONE: pmRdata = BYTE_BLANK;
            default:     pmRdata = flashRdata;
        endcase
    end

    assign dmRdata = BYTE_UNDEF;

    wire unusedDm = dmRd ^ dmWr ^ ^dmAddr ^ isGen ^ rfGap ^ rfRamRd;

    AST_PM_BLANK: assert property (@(posedge core_clk) disable iff (!rstSync)
        clk_en && pmReq.rd && !useInfo && !inFlash |=> pmRdata == BYTE_BLANK)
        else $error("unimplemented program read not FFH");
    AST_INFO_SEL: assert property (@(posedge core_clk) disable iff (!rstSync)
        clk_en && pmReq.rd && infoEn && inOverlay |=> pmRegion == ASD_PM_INFO)
        else $error("overlay not selected");
    AST_INFO_OFF: assert property (@(posedge core_clk) disable iff (!rstSync)
        clk_en && pmReq.rd && !infoEn |=> pmRegion != ASD_PM_INFO)
        else $error("overlay used while disabled");
    AST_INFO_RO: assert property (@(posedge core_clk) disable iff (!rstSync)
        clk_en && pmReq.wr && (inOverlay || pa >= 16'(FLASH_BYTES))
        |-> !flashWe)
        else $error("write reached info area");
    AST_GAP_WR: assert property (@(posedge core_clk) disable iff (!rstSync)
        rfReq.wr && rfGap |-> !ramWe && !ctrlSel)
        else $error("gap write not ignored");
    AST_CTRL: assert property (@(posedge core_clk) disable iff (!rstSync)
        ctrlSel |-> rfAddr[11:8] == 4'hf)
        else $error("control select outside top page");
    AST_DM: assert property (@(posedge core_clk) disable iff (!rstSync)
        dmRd |=> dmRdata == BYTE_UNDEF)
        else $error("data memory decoded");
    AST_RSV: assert property (@(posedge core_clk) disable iff (!rstSync)
        clk_en && pmReq.rd && pa == PM_RSV_BASE && FLASH_BYTES > 64
        |=> pmRegion == ASD_PM_RSV)
        else $error("reserved vector slot misdecoded");
    AST_GAP_RD: assert property (@(posedge core_clk) disable iff (!rstSync)
        clk_en && rfGap |=> rfRdata == BYTE_UNDEF)
        else $error("gap read not filler");
    AST_CTRL_RD: assert property (@(posedge core_clk) disable iff (!rstSync)
        clk_en && ctrlSel && rfReq.rd |=> rfRdata == $past(ctrlRdata))
        else $error("control read data not returned");
    AST_PM_FLASH: assert property (@(posedge core_clk) disable iff (!rstSync)
        clk_en && pmReq.rd && !useInfo && inFlash |=> pmRdata == flashRdata)
        else $error("flash read not returned");
endmodule : asd_decoder
`default_nettype wire

// ### asd_pkg.sv
// Address map constants and carrier types for the address space decoder
package asd_pkg;
    localparam int RF_AW = 12;
    localparam int PM_AW = 16;
    localparam int DW    = 8;
    localparam logic [11:0] RF_RAM_BASE  = 12'h000;
    localparam logic [11:0] RF_CTRL_BASE = 12'hf00;
    localparam logic [11:0] RF_CTRL_LAST = 12'hfff;
    localparam int RF_RAM_DEF_BYTES = 1024;
    localparam int PM_FLASH_DEF_BYTES = 4096;
    localparam logic [15:0] PM_OPT_BASE  = 16'h0000;
    localparam logic [15:0] PM_RST_VEC   = 16'h0002;
    localparam logic [15:0] PM_WDV_VEC   = 16'h0004;
    localparam logic [15:0] PM_ILL_VEC   = 16'h0006;
    localparam logic [15:0] PM_IRQ_BASE  = 16'h0008;
    localparam logic [15:0] PM_IRQ_LAST  = 16'h0037;
    localparam logic [15:0] PM_RSV_BASE  = 16'h0038;
    localparam logic [15:0] PM_OSC_BASE  = 16'h003a;
    localparam logic [15:0] PM_OSC_LAST  = 16'h003d;
    localparam logic [15:0] PM_GEN_BASE  = 16'h003e;
    localparam logic [15:0] PM_INFO_BASE = 16'hfe00;
    localparam logic [15:0] PM_INFO_LAST = 16'hff7f;
    localparam int INFO_BYTES = 128;
    localparam int INFO_PN_BASE  = 64;
    localparam int INFO_PN_LEN   = 20;
    localparam int PAGE_INFO_BIT = 7;
    localparam logic [7:0] BYTE_BLANK = 8'hff;
    localparam logic [7:0] BYTE_UNDEF = 8'h00;

    typedef enum logic [2:0] {
        ASD_PM_OPT = 3'b000, ASD_PM_VEC = 3'b001, ASD_PM_RSV = 3'b010,
        ASD_PM_GEN = 3'b011, ASD_PM_NONE = 3'b100, ASD_PM_INFO = 3'b101
    } asd_pm_region_e;

    typedef enum logic [1:0] {
        ASD_RF_RAM = 2'b00, ASD_RF_GAP = 2'b01, ASD_RF_CTRL = 2'b10
    } asd_rf_region_e;

    typedef struct packed {
        logic          rd;
        logic          wr;
        logic [11:0]   addr;
        logic [7:0]    wdata;
    } asd_rf_req_s;

    typedef struct packed {
        logic          rd;
        logic          wr;
        logic [15:0]   addr;
        logic [7:0]    wdata;
    } asd_pm_req_s;
endpackage : asd_pkg

// ### asd_ram.sv
// Single-port byte RAM with registered read data
`timescale 1ns/1ps
`default_nettype none
module asd_ram #(
    parameter int DEPTH = 1024,
    parameter int AW    = 10
) (
    input  wire logic          core_clk,
    input  wire logic          ce,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (ce) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule : asd_ram
`default_nettype wire

// ### asd_flash_model.sv
// Behavioural flash array that answers the decoder's program port
`timescale 1ns/1ps
`default_nettype none
module asd_flash_model #(
    parameter int BYTES = 1024
) (
    input  wire logic        core_clk,
    input  wire logic        we,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata
);
    logic [7:0] mem [BYTES];
    initial for (int i = 0; i < BYTES; i++) mem[i] = 8'(i ^ (i >> 8)) ^ 8'h5a;
    // array backs only the low bytes
    always @(posedge core_clk) begin
        if (we && addr < BYTES) mem[addr] <= wdata;
        // No byte here, so the read port shows nothing useful
        rdata <= (addr < BYTES) ? mem[addr] : ~rdata;
    end
endmodule : asd_flash_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for the address space decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
    import asd_pkg::*;
    localparam int RAMB = 256;
    localparam int FLB  = 1024;
    localparam logic [8*INFO_BYTES-1:0] INFO =
        {(INFO_BYTES/2){8'hc3, 8'h3c}};
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    asd_rf_req_s rfReq = '0;
    asd_pm_req_s pmReq = '0;
    logic [7:0]  rfRdata, ctrlIndex, pmRdata, flashWdata, flashRdata;
    logic [7:0]  ctrlRdata = 8'h00, dmRdata, pageSelect = 8'h00;
    logic [15:0] flashAddr, dmAddr = 16'h0000;
    logic [2:0]  pmRegion;
    logic        ctrlSel, flashWe, dmRd = 1'b0, dmWr = 1'b0;
    logic [7:0]  ram [RAMB];
    int          fails = 0, n_tests = 0, seed = 1;
    logic [15:0] cor [16] = '{16'h0000, 16'h0001, 16'h0002, 16'h0037,
        16'h0038, 16'h0039, 16'h003a, 16'h003d, 16'h003e, 16'(FLB - 1),
        16'(FLB), 16'hffff, 16'hfe00, 16'hff7f, 16'hfdff, 16'hff80};

    always #25 core_clk = ~core_clk;

    asd_decoder #(.RAM_BYTES(RAMB), .FLASH_BYTES(FLB),
        .INFO_IMAGE(INFO)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .rfReq(rfReq),
        .rfRdata(rfRdata), .ctrlSel(ctrlSel), .ctrlIndex(ctrlIndex),
        .ctrlRdata(ctrlRdata), .pmReq(pmReq), .pmRdata(pmRdata),
        .flashWe(flashWe), .flashAddr(flashAddr), .flashWdata(flashWdata),
        .flashRdata(flashRdata), .pmRegion(pmRegion), .dmRd(dmRd),
        .dmWr(dmWr), .dmAddr(dmAddr), .dmRdata(dmRdata),
        .pageSelect(pageSelect));
    asd_flash_model #(.BYTES(FLB)) flash (.core_clk(core_clk),
        .we(flashWe), .addr(flashAddr), .wdata(flashWdata),
        .rdata(flashRdata));

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic inInfo(input logic [15:0] a, input logic en);
        return en && a >= PM_INFO_BASE && a <= PM_INFO_LAST;
    endfunction : inInfo

    function automatic logic [7:0] pmExp(input logic [15:0] a,
                                         input logic en);
        if (inInfo(a, en)) return a[0] ? 8'hc3 : 8'h3c;
        return (a < FLB) ? (a[7:0] ^ a[15:8] ^ 8'h5a) : BYTE_BLANK;
    endfunction : pmExp

    function automatic logic [2:0] region(input logic [15:0] a,
                                          input logic en);
        if (inInfo(a, en)) return 3'h5;
        if (a < 16'h0002) return 3'h0;
        if (a < 16'h0038) return 3'h1;
        if (a < 16'h003a) return 3'h2;
        if (a < 16'h003e) return 3'h1;
        return (a < FLB) ? 3'h3 : 3'h4;
    endfunction : region

    task automatic rf(input logic wr, input logic [11:0] a,
                      input logic [7:0] d);
        logic ctl;
        ctl = a >= RF_CTRL_BASE;
        @(posedge core_clk);
        rfReq <= '{rd: !wr, wr: wr, addr: a, wdata: d};
        ctrlRdata <= d;
        #1 chk("ctrlSel", 8'(ctrlSel), 8'(ctl));
        if (ctl) chk("ctrlIndex", ctrlIndex, a[7:0]);
        @(posedge core_clk);
        #1;
        if (wr && a < RAMB) ram[a] = d;
        if (!wr) chk("rfRdata", rfRdata,
            ctl ? d : (a < RAMB ? ram[a] : BYTE_UNDEF));
    endtask : rf

    task automatic pm(input logic wr, input logic [15:0] a, input logic en);
        logic [7:0] d;
        d = 8'($random(seed));
        @(posedge core_clk);
        pageSelect <= {en, 7'($random(seed))};
        pmReq <= '{rd: !wr, wr: wr, addr: a, wdata: d};
        dmRd <= 1'($random(seed));
        dmWr <= 1'($random(seed));
        dmAddr <= 16'($random(seed));
        #1;
        if (wr) begin
            chk("flashWe", 8'(flashWe), 8'(a < FLB));
            chk("flashAddrLo", flashAddr[7:0], a[7:0]);
            chk("flashAddrHi", flashAddr[15:8], a[15:8]);
            chk("flashWdata", flashWdata, d);
        end
        @(posedge core_clk);
        #1 chk("dmRdata", dmRdata, 8'h00);
        if (!wr) begin
            chk("pmRdata", pmRdata, pmExp(a, en));
            chk("pmRegion", 8'(pmRegion), 8'(region(a, en)));
        end
    endtask : pm

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    initial begin
        #(50 * 5000);
        fails++;
        summarize();
    end

    initial begin
        logic [11:0] q [$];
        logic [11:0] a;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rf(1, 12'h000, 8'h3c);
        rf(1, 12'(RAMB - 1), 8'hc5);
        rf(1, 12'(RAMB), 8'h99);
        rf(1, 12'heff, 8'h77);
        rf(1, 12'hf42, 8'h18);
        foreach (cor[i]) rf(0, cor[i][11:0] | 12'hf00, 8'($random(seed)));
        rf(0, 12'h000, 8'h00);
        rf(0, 12'(RAMB - 1), 8'h00);
        rf(0, 12'(RAMB), 8'h00);
        rf(0, 12'heff, 8'h00);
        repeat (20) begin
            a = 12'($random(seed)) & 12'(RAMB - 1);
            q.push_back(a);
            rf(1, a, 8'($random(seed)));
        end
        foreach (q[i]) rf(0, q[i], 8'h00);
        $display("test register file done");
        foreach (cor[i]) pm(0, cor[i], 1'b0);
        foreach (cor[i]) pm(0, cor[i], 1'b1);
        repeat (30) pm(0, 16'($random(seed)), 1'($random(seed)));
        pm(1, 16'(FLB), 1'b0);
        pm(0, 16'(FLB), 1'b0);
        pm(1, 16'hfe10, 1'b1);
        pm(0, 16'hfe10, 1'b1);
        pm(1, 16'h0100, 1'b1);
        $display("test program memory done");
        @(posedge core_clk);
        pmReq <= '0;
        rfReq <= '0;
        repeat (2) @(posedge core_clk);
        summarize();
    end
endmodule : tb
`default_nettype wire
